// >>> fpec_params.svh
// Purpose: constants of the program/erase command logic
// Assumes: included by the top module
// Notes: opcodes, frame lengths, page and unit geometry
`ifndef FPEC_PARAMS_SVH
`define FPEC_PARAMS_SVH
// opcodes on the serial link
`define FPEC_OP_LATCH_SET 8'h06
`define FPEC_OP_QPW_A 8'h32
`define FPEC_OP_QPW_B 8'h38
`define FPEC_OP_QPW_W_A 8'h34
`define FPEC_OP_QPW_W_B 8'h3E
`define FPEC_OP_SUE_A 8'hD7
`define FPEC_OP_SUE_B 8'h20
`define FPEC_OP_SUE_W 8'h21
`define FPEC_OP_HBE 8'h52
`define FPEC_OP_HBE_W 8'h5C
`define FPEC_OP_FBE 8'hD8
`define FPEC_OP_FBE_W 8'hDC
`define FPEC_OP_WAE_A 8'hC7
`define FPEC_OP_WAE_B 8'h60
// frame geometry in link clock edges
`define FPEC_CMD_BITS 6'd8
`define FPEC_HDR_NARROW 6'd32
`define FPEC_HDR_WIDE 6'd40
// array geometry
`define FPEC_PAGE_BYTES 9'd256
`define FPEC_SECTOR_SHIFT 12
`define FPEC_BLOCK_BASE_SHIFT 15
`endif

// >>> fpec_pkg.sv
// Purpose: shared types of the program/erase command logic
// Assumes: fpec_params.svh holds the numeric constants
// Notes: array request carrier and command kinds
package fpec_pkg;
    // decoded command kind
    typedef enum logic [2:0] {
        FPEC_K_NONE = 3'h0,
        FPEC_K_LATCH = 3'h1,
        FPEC_K_PROG = 3'h2,
        FPEC_K_SECT = 3'h3,
        FPEC_K_HALF = 3'h4,
        FPEC_K_FULL = 3'h5,
        FPEC_K_CHIP = 3'h6
    } fpec_kind_type;
    // operation asked of the array backend
    typedef enum logic [2:0] {
        FPEC_A_READ = 3'h0,
        FPEC_A_WRITE = 3'h1,
        FPEC_A_ERASE_SECT = 3'h2,
        FPEC_A_ERASE_HALF = 3'h3,
        FPEC_A_ERASE_FULL = 3'h4
    } fpec_arr_op_type;
    // one request to the array backend
    typedef struct packed {
        fpec_arr_op_type op;
        logic [31:0] addr;
        logic [7:0] wdata;
    } fpec_arr_cmd_type;
endpackage : fpec_pkg

// >>> fpec_top.sv
// Purpose: command side of a serial flash for quad page program and erase
// Assumes: link signals sampled on rising link_sclk edges, mode 0
// Notes: array and lock state live outside; this block sequences them
`timescale 1ns/1ps
`include "fpec_params.svh"
module fpec_top #(
    parameter int ADDR_W = 25
) (
    // system clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial link from the host
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic quad_line_0,
    input wire logic quad_line_1,
    input wire logic quad_line_2,
    input wire logic quad_line_3,
    // configuration levels
    input wire logic wide_address_mode,
    input wire logic quad_enable_bit,
    input wire logic [3:0] block_protect_field,
    // other write-class completions and flag clear
    input wire logic wr_class_done,
    input wire logic flag_clr,
    // status outputs
    output logic write_latch,
    output logic busy_flag,
    output logic erase_fail_flag,
    output logic protection_erase_flag,
    // sector lock lookup
    output logic [31:0] lock_query_addr,
    input wire logic lock_hit,
    // array backend
    output logic arr_req,
    output fpec_pkg::fpec_arr_cmd_type arr_cmd,
    input wire logic arr_done,
    input wire logic [7:0] arr_rdata
);
    import fpec_pkg::*;

    // opcode to kind
    function automatic fpec_kind_type kind_of(input logic [7:0] op);
        unique case (op)
            `FPEC_OP_LATCH_SET: kind_of = FPEC_K_LATCH;
            `FPEC_OP_QPW_A, `FPEC_OP_QPW_B,
            `FPEC_OP_QPW_W_A, `FPEC_OP_QPW_W_B: kind_of = FPEC_K_PROG;
            `FPEC_OP_SUE_A, `FPEC_OP_SUE_B, `FPEC_OP_SUE_W: kind_of = FPEC_K_SECT;
            `FPEC_OP_HBE, `FPEC_OP_HBE_W: kind_of = FPEC_K_HALF;
            `FPEC_OP_FBE, `FPEC_OP_FBE_W: kind_of = FPEC_K_FULL;
            `FPEC_OP_WAE_A, `FPEC_OP_WAE_B: kind_of = FPEC_K_CHIP;
            default: kind_of = FPEC_K_NONE;
        endcase
    endfunction : kind_of

    // frame header length: command plus address edges
    function automatic logic [5:0] hdr_of(input logic [7:0] op, input logic wide);
        logic always_wide;
        fpec_kind_type k;
        k = kind_of(op);
        always_wide = (op == `FPEC_OP_QPW_W_A) || (op == `FPEC_OP_QPW_W_B)
            || (op == `FPEC_OP_SUE_W)
            || (op == `FPEC_OP_HBE_W) || (op == `FPEC_OP_FBE_W);
        if (k == FPEC_K_LATCH || k == FPEC_K_CHIP || k == FPEC_K_NONE) begin
            hdr_of = `FPEC_CMD_BITS;
        end else if (always_wide || wide) begin
            hdr_of = `FPEC_HDR_WIDE;
        end else begin
            hdr_of = `FPEC_HDR_NARROW;
        end
    endfunction : hdr_of

    // top region covered by the protect field
    function automatic logic bp_covers(input logic [31:0] a, input logic [3:0] bp);
        logic [31:0] sh;
        logic [31:0] lim;
        sh = a >> (`FPEC_BLOCK_BASE_SHIFT + 32'(bp));
        lim = 32'((64'd1 << ADDR_W) - 64'd1) >> (`FPEC_BLOCK_BASE_SHIFT + 32'(bp));
        bp_covers = (bp != 4'h0) && (sh == lim);
    endfunction : bp_covers

    // ---------------- link domain ----------------
    logic [5:0] pos_r; // edges seen in header
    logic nib_half_r; // high nibble held
    logic [7:0] op_r; // shifted opcode
    logic [31:0] addr_r; // shifted address
    logic [5:0] hdr_r; // header length of frame
    logic over_r; // extra edges on a fixed-length frame
    logic blk_r; // busy seen during this frame
    logic [8:0] nbytes_r; // data bytes, saturating
    logic [3:0] hi_r; // upper nibble
    logic [7:0] wptr_r; // byte pointer in page
    logic [255:0] mask_r; // bytes received
    logic [7:0] page_buf [256]; // page data
    logic busy_s1_r; // busy into link domain
    logic busy_s2_r;
    logic wide_s1_r; // wide mode into link domain
    logic wide_s2_r;

    wire logic [3:0] nib_w = {quad_line_3, quad_line_2, quad_line_1, quad_line_0};
    wire logic [5:0] hdr_w = hdr_of(op_r, wide_s2_r);
    wire logic in_hdr_w = (pos_r < `FPEC_CMD_BITS) || (pos_r < hdr_w);
    wire logic data_w = !in_hdr_w && (kind_of(op_r) == FPEC_K_PROG);
    wire logic [7:0] byte_w = {hi_r, nib_w};
    wire logic take_w = data_w && !busy_s2_r && !blk_r;

    // position and nibble phase, restart while select is high
    always_ff @(posedge link_sclk or posedge link_cs_n or posedge sys_rst) begin
        if (sys_rst || link_cs_n) begin
            pos_r <= 6'h00;
            nib_half_r <= 1'b0;
        end else begin
            if (in_hdr_w) begin
                pos_r <= pos_r + 6'h01;
            end
            if (data_w) begin
                nib_half_r <= !nib_half_r;
            end
        end
    end

    // busy and wide mode synchronisers on the link clock
    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_s1_r <= 1'b0;
            busy_s2_r <= 1'b0;
            wide_s1_r <= 1'b0;
            wide_s2_r <= 1'b0;
        end else begin
            busy_s1_r <= busy_flag;
            busy_s2_r <= busy_s1_r;
            wide_s1_r <= wide_address_mode;
            wide_s2_r <= wide_s1_r;
        end
    end

    // frame capture: opcode, address, header edge count, page bytes
    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            op_r <= 8'h00;
            addr_r <= 32'h0000_0000;
            hdr_r <= 6'h00;
            over_r <= 1'b0;
            blk_r <= 1'b0;
            nbytes_r <= 9'h000;
            hi_r <= 4'h0;
            wptr_r <= 8'h00;
            mask_r <= '0;
        end else begin
            if (pos_r == 6'h00) begin
                over_r <= 1'b0;
                addr_r <= 32'h0000_0000;
            end
            if (pos_r < `FPEC_CMD_BITS) begin
                op_r <= {op_r[6:0], quad_line_0};
            end else if (in_hdr_w) begin
                addr_r <= {addr_r[30:0], quad_line_0};
                if (pos_r == hdr_w - 6'h01) begin
                    wptr_r <= {addr_r[6:0], quad_line_0};
                end
            end else if (!data_w) begin
                over_r <= 1'b1;
            end
            // header edges seen, judged once select rises
            if (in_hdr_w) begin
                hdr_r <= pos_r + 6'h01;
            end
            // synced busy is stale at frame start, fresh after the opcode
            if (pos_r == `FPEC_CMD_BITS - 6'h01) begin
                blk_r <= busy_s2_r;
                if (!busy_s2_r) begin
                    mask_r <= '0;
                    nbytes_r <= 9'h000;
                end
            end else if (pos_r >= `FPEC_CMD_BITS) begin
                blk_r <= blk_r || busy_s2_r;
            end
            if (take_w && !nib_half_r) begin
                hi_r <= nib_w;
            end else if (take_w) begin
                mask_r[wptr_r] <= 1'b1;
                wptr_r <= wptr_r + 8'h01;
                if (nbytes_r != `FPEC_PAGE_BYTES) begin
                    nbytes_r <= nbytes_r + 9'h001;
                end
            end
        end
    end

    // page buffer write, later bytes overwrite earlier
    always_ff @(posedge link_sclk) begin
        if (take_w && nib_half_r) begin
            page_buf[wptr_r] <= byte_w;
        end
    end

    a_page_wrap: assert property (@(posedge link_sclk) disable iff (sys_rst)
        (take_w && nib_half_r && wptr_r == 8'hFF) |=> (wptr_r == 8'h00))
        else $error("page pointer did not wrap");

    // ---------------- system domain ----------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LOCK = 7'h02,
        ST_SCAN = 7'h04,
        ST_RD = 7'h08,
        ST_WR = 7'h10,
        ST_ERASE = 7'h20,
        ST_FINISH = 7'h40
    } fpec_state_type;

    fpec_state_type state_r; // sequencer state
    fpec_kind_type kind_r; // running command
    logic cs_s1_r; // select synchroniser
    logic cs_s2_r;
    logic cs_s3_r; // edge history
    logic [31:0] cur_r; // current unit or page address
    logic [7:0] idx_r; // page byte index
    logic [7:0] old_r; // byte read back
    logic write_latch_r;
    logic busy_flag_r;
    logic efail_r;
    logic prot_r;
    logic [31:0] lq_r;
    logic arr_req_r;
    fpec_arr_cmd_type arr_cmd_r;

    wire logic rise_w = cs_s2_r && !cs_s3_r;
    wire fpec_kind_type fk_w = kind_of(op_r);
    wire logic is_prog_w = fk_w == FPEC_K_PROG;
    // link registers are still while select is high, so read them here
    wire logic clean_w = (hdr_r == hdr_w) && !blk_r && (is_prog_w
        ? (nbytes_r != 9'h000) : !over_r);
    wire logic accept_w = rise_w && state_r == ST_IDLE && clean_w
        && fk_w != FPEC_K_NONE;
    wire logic needs_latch_w = accept_w && fk_w != FPEC_K_LATCH;
    wire logic go_w = needs_latch_w && write_latch_r;
    wire logic chip_refuse_w = go_w && fk_w == FPEC_K_CHIP
        && block_protect_field != 4'h0;
    wire logic [31:0] sect_mask_w = ~((32'h1 << `FPEC_SECTOR_SHIFT) - 32'h1);
    wire logic [31:0] unit_w = (fk_w == FPEC_K_PROG) ? {addr_r[31:8], 8'h00}
        : (fk_w == FPEC_K_CHIP) ? 32'h0 : (addr_r & sect_mask_w);
    wire logic bp_hit_w = bp_covers(unit_w, block_protect_field);
    wire logic [31:0] last_sect_w = 32'((64'd1 << ADDR_W) - 64'd1) & sect_mask_w;
    wire logic [31:0] next_sect_w = cur_r + (32'h1 << `FPEC_SECTOR_SHIFT);
    wire logic [31:0] byte_addr_w = {cur_r[31:8], idx_r};
    wire fpec_arr_op_type erase_op_w = (kind_r == FPEC_K_HALF) ? FPEC_A_ERASE_HALF
        : (kind_r == FPEC_K_FULL) ? FPEC_A_ERASE_FULL : FPEC_A_ERASE_SECT;

    // select synchroniser; the second and third stages feed the rise detect
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= link_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    // write latch: set wins over completion clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            write_latch_r <= 1'b0;
        end else if (accept_w && fk_w == FPEC_K_LATCH) begin
            write_latch_r <= 1'b1;
        end else if (state_r == ST_FINISH || wr_class_done) begin
            write_latch_r <= 1'b0;
        end
    end

    // sticky erase error flags, set wins over clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            efail_r <= 1'b0;
            prot_r <= 1'b0;
        end else if (chip_refuse_w) begin
            efail_r <= 1'b1;
            prot_r <= 1'b1;
        end else if (flag_clr) begin
            efail_r <= 1'b0;
            prot_r <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            kind_r <= FPEC_K_NONE;
            cur_r <= 32'h0;
            idx_r <= 8'h00;
            old_r <= 8'h00;
            busy_flag_r <= 1'b0;
            lq_r <= 32'h0;
            arr_req_r <= 1'b0;
            arr_cmd_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    // start only when the frame is clean and not protected
                    if (go_w && !chip_refuse_w && !bp_hit_w) begin
                        kind_r <= fk_w;
                        cur_r <= unit_w;
                        lq_r <= unit_w;
                        idx_r <= 8'h00;
                        busy_flag_r <= 1'b1;
                        state_r <= ST_LOCK;
                    end
                end
                ST_LOCK: begin
                    // sector lock answer for lq_r
                    if (lock_hit && kind_r == FPEC_K_CHIP) begin
                        state_r <= ST_ERASE;
                    end else if (lock_hit) begin
                        busy_flag_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (kind_r == FPEC_K_PROG) begin
                        state_r <= ST_SCAN;
                    end else begin
                        arr_req_r <= 1'b1;
                        arr_cmd_r <= '{op: erase_op_w, addr: cur_r, wdata: 8'hFF};
                        state_r <= ST_ERASE;
                    end
                end
                ST_SCAN: begin
                    // visit only bytes that were sent
                    if (mask_r[idx_r]) begin
                        arr_req_r <= 1'b1;
                        arr_cmd_r <= '{op: FPEC_A_READ, addr: byte_addr_w, wdata: 8'h00};
                        state_r <= ST_RD;
                    end else if (idx_r == 8'hFF) begin
                        state_r <= ST_FINISH;
                    end else begin
                        idx_r <= idx_r + 8'h01;
                    end
                end
                ST_RD: begin
                    if (arr_done) begin
                        old_r <= arr_rdata;
                        arr_cmd_r <= '{op: FPEC_A_WRITE, addr: byte_addr_w,
                            wdata: arr_rdata & page_buf[idx_r]};
                        state_r <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (arr_done) begin
                        arr_req_r <= 1'b0;
                        idx_r <= idx_r + 8'h01;
                        state_r <= (idx_r == 8'hFF) ? ST_FINISH : ST_SCAN;
                    end
                end
                ST_ERASE: begin
                    // chip erase walks sectors, skipped ones issue nothing
                    if (arr_done || !arr_req_r) begin
                        arr_req_r <= 1'b0;
                        if (kind_r == FPEC_K_CHIP && cur_r != last_sect_w) begin
                            cur_r <= next_sect_w;
                            lq_r <= next_sect_w;
                            state_r <= ST_LOCK;
                        end else begin
                            state_r <= ST_FINISH;
                        end
                    end
                end
                ST_FINISH: begin
                    busy_flag_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // outputs straight from flip-flops
    assign write_latch = write_latch_r;
    assign busy_flag = busy_flag_r;
    assign erase_fail_flag = efail_r;
    assign protection_erase_flag = prot_r;
    assign lock_query_addr = lq_r;
    assign arr_req = arr_req_r;
    assign arr_cmd = arr_cmd_r;

    // assertions
    sequence s_start;
        go_w && !chip_refuse_w && !bp_hit_w;
    endsequence
    sequence s_locked_prog;
        state_r == ST_LOCK && lock_hit && kind_r == FPEC_K_PROG;
    endsequence

    a_latch_set_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        (accept_w && fk_w == FPEC_K_LATCH) |=> write_latch_r)
        else $error("latch set command did not set latch");
    a_busy_on_start: assert property (@(posedge clk) disable iff (sys_rst)
        s_start |=> busy_flag_r && state_r == ST_LOCK)
        else $error("busy not raised on start");
    a_finish_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_FINISH) |=> !busy_flag_r && !write_latch_r)
        else $error("completion did not clear busy and latch");
    a_chip_refused: assert property (@(posedge clk) disable iff (sys_rst)
        chip_refuse_w |=> efail_r && prot_r && !busy_flag_r)
        else $error("protected chip erase not refused");
    a_busy_ignores: assert property (@(posedge clk) disable iff (sys_rst)
        (rise_w && busy_flag_r && state_r != ST_FINISH) |=> busy_flag_r
            && $stable(kind_r))
        else $error("command taken while busy");
    a_only_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (arr_req_r && arr_cmd_r.op == FPEC_A_WRITE) |-> ((arr_cmd_r.wdata & ~old_r) == 8'h00))
        else $error("program would set a bit");
    a_needs_latch: assert property (@(posedge clk) disable iff (sys_rst)
        (needs_latch_w && !write_latch_r && !busy_flag_r) |=> !busy_flag_r)
        else $error("write started without latch");
    a_locked_skip: assert property (@(posedge clk) disable iff (sys_rst)
        s_locked_prog |=> !arr_req_r && !busy_flag_r ##1 !arr_req_r)
        else $error("locked page was programmed");
    a_lock_no_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_LOCK && lock_hit && kind_r == FPEC_K_CHIP) |=> $stable(efail_r)
            || $fell(efail_r))
        else $error("lock raised an erase flag");
endmodule : fpec_top

// >>> fpec_host_model.sv
// Purpose: host end of the serial link, sends whole frames on request
// Assumes: mode 0, 12 ns link clock that runs only inside frames
// Notes: data lines are inverted between frames so stale values never help
`timescale 1ns/1ps
module fpec_host_model (
    // serial link toward the device
    output logic link_sclk,
    output logic link_cs_n,
    output logic quad_line_0,
    output logic quad_line_1,
    output logic quad_line_2,
    output logic quad_line_3
);
    // four data lines, line 3 is the top bit
    logic [3:0] q = 4'h0;
    assign {quad_line_3, quad_line_2, quad_line_1, quad_line_0} = q;
    // idle: deselected, clock parked low
    initial begin
        link_cs_n = 1'b1;
        link_sclk = 1'b0;
    end
    // one rising link edge carrying v
    task automatic tick(input logic [3:0] v);
        q = v;
        #6 link_sclk = 1'b1;
        #6 link_sclk = 1'b0;
    endtask : tick
    // opcode, na address bits, nb bytes of d0 ^ index[8:1]
    task automatic frame(input logic [7:0] op, input int na, input logic [31:0] adr,
                         input int nb, input logic [7:0] d0);
        logic [7:0] d;
        link_cs_n = 1'b0;
        #6;
        for (int i = 7; i >= 0; i--) tick({3'h5, op[i]});
        for (int i = na - 1; i >= 0; i--) tick({3'h2, adr[i]});
        for (int i = 0; i < nb; i++) begin
            d = d0 ^ i[8:1];
            tick(d[7:4]);
            tick(d[3:0]);
        end
        #6 link_cs_n = 1'b1;
        q = ~q;
    endtask : frame
endmodule : fpec_host_model

// >>> fpec_top_tb_top.sv
// Purpose: self-checking bench of the program/erase command logic
// Assumes: 16-bit array, behavioural backend and lock lookup kept here
// Notes: link frames come from fpec_host_model
`timescale 1ns/1ps
module fpec_top_tb_top;
    import fpec_pkg::*;
    // clock, reset, levels and pulses
    logic clk, sys_rst, wide_address_mode, quad_enable_bit, wr_class_done, flag_clr, lock_hit;
    logic [3:0] block_protect_field;
    logic link_sclk, link_cs_n, quad_line_0, quad_line_1, quad_line_2, quad_line_3;
    logic write_latch, busy_flag, erase_fail_flag, protection_erase_flag, arr_req;
    logic [31:0] lock_query_addr;
    logic arr_done;
    logic [7:0] arr_rdata = 8'h00;
    fpec_arr_cmd_type arr_cmd;
    // backend memory, erase log and answer delay
    logic [7:0] mem [int];
    int err_total = 0, n_tests = 0, n_erase = 0, delay = 0, cnt = 0;
    fpec_arr_op_type last_op;
    logic lock_on;

    fpec_top #(.ADDR_W(16)) dut (.clk, .sys_rst, .link_sclk, .link_cs_n, .quad_line_0,
        .quad_line_1, .quad_line_2, .quad_line_3, .wide_address_mode, .quad_enable_bit,
        .block_protect_field, .wr_class_done, .flag_clr, .write_latch, .busy_flag,
        .erase_fail_flag, .protection_erase_flag, .lock_query_addr, .lock_hit, .arr_req,
        .arr_cmd, .arr_done, .arr_rdata);
    fpec_host_model host (.link_sclk, .link_cs_n, .quad_line_0, .quad_line_1,
        .quad_line_2, .quad_line_3);

    // sector 3 reads as locked while lock_on
    assign lock_hit = lock_on && (lock_query_addr[15:12] == 4'h3);
    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // backend: one done pulse per command after delay cycles
    always @(negedge clk) begin
        arr_done <= arr_req && !arr_done && cnt >= delay;
        if (arr_req && !arr_done && cnt >= delay) begin
            cnt <= 0;
            if (arr_cmd.op == FPEC_A_READ) begin
                arr_rdata <= mem.exists(arr_cmd.addr) ? mem[arr_cmd.addr] : 8'hFF;
            end else if (arr_cmd.op == FPEC_A_WRITE) begin
                mem[arr_cmd.addr] = arr_cmd.wdata;
            end else begin
                n_erase <= n_erase + 1;
                last_op <= arr_cmd.op;
            end
        end else if (arr_req && !arr_done) begin
            cnt <= cnt + 1;
        end
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // wait out the operation, then the select-high gap
    task automatic idle;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 5000 && busy_flag !== 1'b0; i++) @(negedge clk);
        if (busy_flag !== 1'b0) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, busy_flag, 1'b0);
        end
        repeat (4) @(negedge clk);
    endtask : idle
    task automatic cmd(input logic [7:0] op, input int na, input logic [31:0] adr,
                       input int nb, input logic [7:0] d0);
        host.frame(op, na, adr, nb, d0);
        idle();
    endtask : cmd
    task automatic latch;
        cmd(8'h06, 0, 32'h0, 0, 8'h00);
    endtask : latch
    // reset state, missing latch, short frame, other write completion
    task automatic sc_basic;
        chk(write_latch, 1'b0);
        chk(busy_flag, 1'b0);
        cmd(8'h32, 24, 32'h300, 1, 8'h00);
        chk(mem.exists(32'h300), 0);
        latch();
        chk(write_latch, 1'b1);
        cmd(8'h20, 23, 32'h1000, 0, 8'h00);
        chk(n_erase, 0);
        @(negedge clk) wr_class_done = 1'b1;
        @(negedge clk) wr_class_done = 1'b0;
        chk(write_latch, 1'b0);
    endtask : sc_basic
    // three bytes across the page end, latch frame while busy
    task automatic sc_prog;
        mem[32'h1FE] = 8'h0F;
        delay = 4;
        latch();
        host.frame(8'h32, 24, 32'h1FE, 3, 8'hA5);
        repeat (8) @(negedge clk);
        chk(busy_flag, 1'b1);
        cmd(8'h06, 0, 32'h0, 0, 8'h00);
        chk(mem[32'h1FE], 8'h05);
        chk(mem[32'h1FF], 8'hA5);
        chk(mem[32'h100], 8'hA4);
        chk(mem.exists(32'h200), 0);
        chk(write_latch, 1'b0);
        chk(busy_flag, 1'b0);
        delay = 0;
    endtask : sc_prog
    // 258 bytes, wide opcode in narrow mode
    task automatic sc_wrap;
        latch();
        cmd(8'h3E, 32, 32'h400, 258, 8'h25);
        chk(mem[32'h400], 8'hA5);
        chk(mem[32'h402], 8'h24);
        chk(mem[32'h4FF], 8'h5A);
        chk(mem.exists(32'h500), 0);
    endtask : sc_wrap
    // every sector and block erase opcode
    task automatic sc_erase;
        logic [7:0] ops [7] = '{8'h20, 8'hD7, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC};
        for (int i = 0; i < 7; i++) begin
            fpec_arr_op_type e;
            e = (i < 3) ? FPEC_A_ERASE_SECT : (i < 5) ? FPEC_A_ERASE_HALF : FPEC_A_ERASE_FULL;
            wide_address_mode = (i == 1);
            latch();
            cmd(ops[i], (i inside {1, 2, 4, 6}) ? 32 : 24, 32'hA123, 0, 8'h00);
            chk(n_erase, i + 1);
            chk(last_op, e);
            chk(write_latch, 1'b0);
        end
        wide_address_mode = 1'b0;
    endtask : sc_erase
    // protected whole erase, then locked sector skipped
    task automatic sc_chip;
        int n0;
        block_protect_field = 4'h1;
        latch();
        n0 = n_erase;
        cmd(8'hC7, 0, 32'h0, 0, 8'h00);
        chk(erase_fail_flag, 1'b1);
        chk(protection_erase_flag, 1'b1);
        chk(n_erase, n0);
        cmd(8'h38, 24, 32'hF00, 1, 8'h00);
        chk(mem.exists(32'hF00), 0);
        @(negedge clk) flag_clr = 1'b1;
        @(negedge clk) flag_clr = 1'b0;
        chk(erase_fail_flag, 1'b0);
        block_protect_field = 4'h0;
        lock_on = 1'b1;
        delay = 8;
        host.frame(8'h60, 0, 32'h0, 0, 8'h00);
        repeat (8) @(negedge clk);
        cmd(8'h06, 0, 32'h0, 0, 8'h00);
        chk(n_erase - n0, 15);
        chk(protection_erase_flag, 1'b0);
        chk(write_latch, 1'b0);
    endtask : sc_chip
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // watchdog
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end
    // reset, then the scenarios
    initial begin
        sys_rst = 1'b1;
        {wide_address_mode, wr_class_done, flag_clr, lock_on} = 4'h0;
        quad_enable_bit = !sys_rst;
        block_protect_field = 4'h0;
        host.tick(4'h0);
        host.tick(4'h0);
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        quad_enable_bit = !sys_rst;
        repeat (4) @(negedge clk);
        sc_basic();
        sc_prog();
        sc_wrap();
        sc_erase();
        sc_chip();
        end_of_test();
    end
endmodule : fpec_top_tb_top
